// ---- rtl/hss_map.svh ----
// Purpose: address map, field positions and reset values of the strap sampler
// Assumes: 32-bit register words at byte offsets
// Notes: definitions only
`ifndef HSS_MAP_SVH
`define HSS_MAP_SVH

`define HSS_NSTRAP 6
`define HSS_BIT_TOP_SWAP 0
`define HSS_BIT_BOOT_SRC 1
`define HSS_BIT_DESC_SEC 2
`define HSS_BIT_DP0 3
`define HSS_BIT_DP1 4
`define HSS_BIT_PANEL 5
// top swap, boot source and descriptor security default high
`define HSS_STRAP_DEFAULT 6'h07
// decoded outputs at reset: top swap and spi boot on, override and presents off
`define HSS_DEC_RESET 7'h03

`define HSS_OFS_STATUS 8'h00
`define HSS_OFS_PIN_FUNC 8'h04
`define HSS_OFS_GPIO_DIR 8'h08
`define HSS_OFS_GPIO_OUT 8'h0C
`define HSS_OFS_GPIO_IN 8'h10
`define HSS_STATUS_VALID_BIT 8

`define HSS_FUNC_W 2
`define HSS_FUNC_GPIO 2'h0
`define HSS_FUNC_RESET 12'h000
`define HSS_DIR_RESET 6'h00
`define HSS_OUT_RESET 6'h00

`define HSS_FETCH_AW 17
`define HSS_FETCH_MSB 16

`endif

// ---- rtl/hss_pkg.sv ----
// Purpose: shared types of the strap sampler
// Assumes: nothing
// Notes: constants live in hss_map.svh
package hss_pkg;
    typedef enum {HSS_ST_IDLE, HSS_ST_HOLD} hss_phase_t;
    typedef logic [5:0] hss_straps_t;
endpackage : hss_pkg

// ---- rtl/hss_phase.sv ----
// Purpose: strap capture on power-good rise, hold, discard on fall
// Assumes: power-good is synchronous to the core clock
// Notes: a power-good already high at reset release counts as a rise
`include "hss_map.svh"
module hss_phase (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // sampling
    input wire logic i_core_power_good,
    input wire hss_pkg::hss_straps_t i_levels,
    // result
    output hss_pkg::hss_straps_t o_straps,
    output logic o_valid
);
    hss_pkg::hss_phase_t state_reg;
    hss_pkg::hss_phase_t state_next;
    hss_pkg::hss_straps_t straps_reg;
    hss_pkg::hss_straps_t straps_next;
    logic pg_prev_reg;
    wire logic rise;
    wire logic drop;

    assign rise = i_core_power_good & ~pg_prev_reg;
    assign drop = (state_reg == hss_pkg::HSS_ST_HOLD) & ~i_core_power_good;
    // capture only on the rise; defaults return once power-good is gone
    assign straps_next = rise ? i_levels :
                         drop ? `HSS_STRAP_DEFAULT : straps_reg;

    always_comb begin
        case (state_reg)
            hss_pkg::HSS_ST_IDLE: state_next = rise ? hss_pkg::HSS_ST_HOLD : hss_pkg::HSS_ST_IDLE;
            hss_pkg::HSS_ST_HOLD: state_next = drop ? hss_pkg::HSS_ST_IDLE : hss_pkg::HSS_ST_HOLD;
            default: state_next = hss_pkg::HSS_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= hss_pkg::HSS_ST_IDLE;
            straps_reg <= `HSS_STRAP_DEFAULT;
            pg_prev_reg <= 1'b0;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            straps_reg <= straps_next;
            pg_prev_reg <= i_core_power_good;
        end
    end

    assign o_straps = straps_reg;
    assign o_valid = (state_reg == hss_pkg::HSS_ST_HOLD);

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    a_capture_on_rise: assert property (
        i_clk_en && i_resetn && i_core_power_good && !pg_prev_reg
        |=> o_valid && o_straps == $past(i_levels))
        else $error("straps not captured on power-good rise");
    a_hold_stable: assert property (
        o_valid && i_core_power_good |=> $stable(o_straps) && o_valid)
        else $error("latched straps moved while power-good high");
    a_discard_on_fall: assert property (
        o_valid && !i_core_power_good && i_clk_en |=> !o_valid && o_straps == `HSS_STRAP_DEFAULT)
        else $error("straps not discarded on power-good fall");
endmodule : hss_phase

// ---- rtl/hss_pad.sv ----
// Purpose: one strap pad: internal termination, gpio drive after release
// Assumes: i_pin_driven tells whether anything outside drives the pin
// Notes: the pad never drives before the strap phase has captured
`include "hss_map.svh"
module hss_pad #(
    parameter logic P_DEFAULT = 1'b0
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // pin side
    input wire logic i_pin,
    input wire logic i_pin_driven,
    output logic o_pin,
    output logic o_pin_oe,
    // control side
    input wire logic [1:0] i_func,
    input wire logic i_dir,
    input wire logic i_out,
    input wire logic i_released,
    output logic o_level
);
    logic oe_reg;
    logic out_reg;
    wire logic oe_next;

    // an undriven pin reads as its internal pull
    assign o_level = oe_reg ? out_reg : (i_pin_driven ? i_pin : P_DEFAULT);
    // only a function-0 gpio set to output drives, and only after release
    assign oe_next = i_released & (i_func == `HSS_FUNC_GPIO) & i_dir;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            oe_reg <= 1'b0;
            out_reg <= 1'b0;
        end else if (i_clk_en) begin
            oe_reg <= oe_next;
            out_reg <= i_out;
        end
    end

    assign o_pin = out_reg;
    assign o_pin_oe = oe_reg;

    a_quiet_before_release: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        !i_released && i_clk_en |=> !o_pin_oe)
        else $error("strap pad drove before release");
endmodule : hss_pad

// ---- rtl/hss_top.sv ----
// Purpose: hardware strap sampler with gpio release and Avalon-MM registers
// Assumes: all inputs synchronous to i_core_clk; one wait state per access
// Notes: strap outputs show the defaults until the first capture
`include "hss_map.svh"
module hss_top (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // power
    input wire logic i_core_power_good,
    // top swap strap pin
    input wire logic i_top_swap_strap_pin,
    input wire logic i_top_swap_strap_pin_driven,
    output logic o_top_swap_strap_pin,
    output logic o_top_swap_strap_pin_oe,
    // boot source strap pin
    input wire logic i_boot_source_strap_pin,
    input wire logic i_boot_source_strap_pin_driven,
    output logic o_boot_source_strap_pin,
    output logic o_boot_source_strap_pin_oe,
    // descriptor security strap pin
    input wire logic i_descriptor_security_strap_pin,
    input wire logic i_descriptor_security_strap_pin_driven,
    output logic o_descriptor_security_strap_pin,
    output logic o_descriptor_security_strap_pin_oe,
    // display port 0 detect pin
    input wire logic i_display_port0_detect_pin,
    input wire logic i_display_port0_detect_pin_driven,
    output logic o_display_port0_detect_pin,
    output logic o_display_port0_detect_pin_oe,
    // display port 1 detect pin
    input wire logic i_display_port1_detect_pin,
    input wire logic i_display_port1_detect_pin_driven,
    output logic o_display_port1_detect_pin,
    output logic o_display_port1_detect_pin_oe,
    // serial panel detect pin
    input wire logic i_serial_panel_detect_pin,
    input wire logic i_serial_panel_detect_pin_driven,
    output logic o_serial_panel_detect_pin,
    output logic o_serial_panel_detect_pin_oe,
    // boot fetch address path
    input wire logic [16:0] i_fetch_addr,
    output logic [16:0] o_fetch_addr,
    // decoded straps
    output logic o_strap_valid,
    output logic o_top_swap_active,
    output logic o_boot_from_spi,
    output logic o_descriptor_override,
    output logic o_display_port0_present,
    output logic o_display_port1_present,
    output logic o_serial_panel_present,
    // avalon-mm slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest
);
    localparam hss_pkg::hss_straps_t strap_default = `HSS_STRAP_DEFAULT;

    wire hss_pkg::hss_straps_t pin_in;
    wire hss_pkg::hss_straps_t pin_drv;
    wire hss_pkg::hss_straps_t pin_out;
    wire hss_pkg::hss_straps_t pin_oe;
    wire hss_pkg::hss_straps_t levels;
    wire hss_pkg::hss_straps_t straps_w;
    wire logic valid_w;

    logic [11:0] func_reg;
    logic [11:0] func_next;
    logic [5:0] dir_reg;
    logic [5:0] dir_next;
    logic [5:0] gpout_reg;
    logic [5:0] gpout_next;
    logic waitreq_reg;
    logic waitreq_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [16:0] fetch_reg;
    logic [16:0] fetch_next;
    logic [6:0] dec_reg;
    logic [6:0] dec_next;

    assign pin_in = {i_serial_panel_detect_pin, i_display_port1_detect_pin,
                     i_display_port0_detect_pin, i_descriptor_security_strap_pin,
                     i_boot_source_strap_pin, i_top_swap_strap_pin};
    assign pin_drv = {i_serial_panel_detect_pin_driven, i_display_port1_detect_pin_driven,
                      i_display_port0_detect_pin_driven,
                      i_descriptor_security_strap_pin_driven,
                      i_boot_source_strap_pin_driven, i_top_swap_strap_pin_driven};

    hss_phase u_phase (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_core_power_good(i_core_power_good),
        .i_levels(levels),
        .o_straps(straps_w),
        .o_valid(valid_w)
    );

    // pads stay inputs with their pulls until the capture has happened
    genvar gi;
    generate
        for (gi = 0; gi < `HSS_NSTRAP; gi++) begin : g_pad
            hss_pad #(.P_DEFAULT(strap_default[gi])) u_pad (
                .i_core_clk(i_core_clk),
                .i_resetn(i_resetn),
                .i_clk_en(i_clk_en),
                .i_pin(pin_in[gi]),
                .i_pin_driven(pin_drv[gi]),
                .o_pin(pin_out[gi]),
                .o_pin_oe(pin_oe[gi]),
                .i_func(func_reg[gi*`HSS_FUNC_W +: `HSS_FUNC_W]),
                .i_dir(dir_reg[gi]),
                .i_out(gpout_reg[gi]),
                .i_released(valid_w),
                .o_level(levels[gi])
            );

            a_undriven_default: assert property (
                @(posedge i_core_clk) disable iff (!i_resetn)
                $rose(valid_w) && $past(!pin_drv[gi] && !pin_oe[gi])
                |-> straps_w[gi] == strap_default[gi])
                else $error("undriven strap did not sample its default");
        end
    endgenerate

    assign o_top_swap_strap_pin = pin_out[`HSS_BIT_TOP_SWAP];
    assign o_top_swap_strap_pin_oe = pin_oe[`HSS_BIT_TOP_SWAP];
    assign o_boot_source_strap_pin = pin_out[`HSS_BIT_BOOT_SRC];
    assign o_boot_source_strap_pin_oe = pin_oe[`HSS_BIT_BOOT_SRC];
    assign o_descriptor_security_strap_pin = pin_out[`HSS_BIT_DESC_SEC];
    assign o_descriptor_security_strap_pin_oe = pin_oe[`HSS_BIT_DESC_SEC];
    assign o_display_port0_detect_pin = pin_out[`HSS_BIT_DP0];
    assign o_display_port0_detect_pin_oe = pin_oe[`HSS_BIT_DP0];
    assign o_display_port1_detect_pin = pin_out[`HSS_BIT_DP1];
    assign o_display_port1_detect_pin_oe = pin_oe[`HSS_BIT_DP1];
    assign o_serial_panel_detect_pin = pin_out[`HSS_BIT_PANEL];
    assign o_serial_panel_detect_pin_oe = pin_oe[`HSS_BIT_PANEL];

    // strap decode, registered so the outputs are flop driven
    assign dec_next = {valid_w,
                       straps_w[`HSS_BIT_PANEL],
                       straps_w[`HSS_BIT_DP1],
                       straps_w[`HSS_BIT_DP0],
                       ~straps_w[`HSS_BIT_DESC_SEC],
                       straps_w[`HSS_BIT_BOOT_SRC],
                       straps_w[`HSS_BIT_TOP_SWAP]};
    // top swap flips only the uppermost fetch address bit
    assign fetch_next = {i_fetch_addr[`HSS_FETCH_MSB] ^ straps_w[`HSS_BIT_TOP_SWAP],
                         i_fetch_addr[`HSS_FETCH_MSB-1:0]};

    // register bus: one wait state, then a single answer cycle
    wire logic req = i_read | i_write;
    wire logic accept = req & waitreq_reg;
    wire logic wr_fire = i_write & ~waitreq_reg;
    wire logic sel_status = (i_address == `HSS_OFS_STATUS);
    wire logic sel_func = (i_address == `HSS_OFS_PIN_FUNC);
    wire logic sel_dir = (i_address == `HSS_OFS_GPIO_DIR);
    wire logic sel_out = (i_address == `HSS_OFS_GPIO_OUT);
    wire logic sel_in = (i_address == `HSS_OFS_GPIO_IN);
    wire logic [31:0] be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                                 {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    wire logic [31:0] func_merge = ({20'h00000, func_reg} & ~be_mask) | (i_writedata & be_mask);
    wire logic [31:0] dir_merge = ({26'h0000000, dir_reg} & ~be_mask) | (i_writedata & be_mask);
    wire logic [31:0] out_merge = ({26'h0000000, gpout_reg} & ~be_mask) | (i_writedata & be_mask);
    // unmapped addresses read zero and swallow writes
    wire logic [31:0] rd_mux =
        sel_status ? {23'h000000, valid_w, 2'h0, straps_w} :
        sel_func ? {20'h00000, func_reg} :
        sel_dir ? {26'h0000000, dir_reg} :
        sel_out ? {26'h0000000, gpout_reg} :
        sel_in ? {26'h0000000, levels} : 32'h00000000;

    assign waitreq_next = ~accept;
    assign rdata_next = (accept & i_read) ? rd_mux : rdata_reg;
    assign func_next = (wr_fire & sel_func) ? func_merge[11:0] : func_reg;
    assign dir_next = (wr_fire & sel_dir) ? dir_merge[5:0] : dir_reg;
    assign gpout_next = (wr_fire & sel_out) ? out_merge[5:0] : gpout_reg;

    // pins wake as function 0 inputs
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            func_reg <= `HSS_FUNC_RESET;
            dir_reg <= `HSS_DIR_RESET;
            gpout_reg <= `HSS_OUT_RESET;
        end else if (i_clk_en) begin
            func_reg <= func_next;
            dir_reg <= dir_next;
            gpout_reg <= gpout_next;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            waitreq_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else if (i_clk_en) begin
            waitreq_reg <= waitreq_next;
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dec_reg <= `HSS_DEC_RESET;
            fetch_reg <= 17'h00000;
        end else if (i_clk_en) begin
            dec_reg <= dec_next;
            fetch_reg <= fetch_next;
        end
    end

    assign o_top_swap_active = dec_reg[0];
    assign o_boot_from_spi = dec_reg[1];
    assign o_descriptor_override = dec_reg[2];
    assign o_display_port0_present = dec_reg[3];
    assign o_display_port1_present = dec_reg[4];
    assign o_serial_panel_present = dec_reg[5];
    assign o_strap_valid = dec_reg[6];
    assign o_fetch_addr = fetch_reg;
    assign o_readdata = rdata_reg;
    assign o_waitrequest = waitreq_reg;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    // sampled reset in the antecedents keeps the release edge from starting a check
    a_top_swap_addr: assert property (
        i_clk_en && i_resetn |=> o_fetch_addr == ($past(i_fetch_addr)
            ^ {$past(straps_w[`HSS_BIT_TOP_SWAP]), 16'h0000}))
        else $error("fetch address top bit wrong for top swap");
    a_boot_source: assert property (
        i_clk_en && i_resetn |=> o_boot_from_spi == $past(straps_w[`HSS_BIT_BOOT_SRC]))
        else $error("boot source decode wrong");
    a_desc_override: assert property (
        i_clk_en && i_resetn |=> o_descriptor_override == !$past(straps_w[`HSS_BIT_DESC_SEC]))
        else $error("descriptor override decode wrong");
    a_port0_detect: assert property (
        i_clk_en && i_resetn |=> o_display_port0_present == $past(straps_w[`HSS_BIT_DP0]))
        else $error("display port 0 detect wrong");
    a_port1_detect: assert property (
        i_clk_en && i_resetn |=> o_display_port1_present == $past(straps_w[`HSS_BIT_DP1]))
        else $error("display port 1 detect wrong");
    a_panel_detect: assert property (
        i_clk_en && i_resetn |=> o_serial_panel_present == $past(straps_w[`HSS_BIT_PANEL]))
        else $error("serial panel detect wrong");
    a_idle_defaults: assert property (
        !o_strap_valid && !valid_w |-> o_boot_from_spi && !o_descriptor_override
            && !o_display_port0_present && o_top_swap_active
            && !o_display_port1_present && !o_serial_panel_present)
        else $error("outputs not at defaults outside strap hold");
    a_valid_lag: assert property (
        i_clk_en && i_resetn |=> o_strap_valid == $past(valid_w))
        else $error("strap valid does not follow the hold state");
    // the pads must be back to inputs by the time the defaults show again
    a_idle_pins_off: assert property (
        !o_strap_valid && !valid_w |-> pin_oe == 6'h00)
        else $error("strap pin driven outside strap hold");
    a_bus_one_wait: assert property (
        i_clk_en && (i_read || i_write) && o_waitrequest ##1 i_clk_en |=> o_waitrequest)
        else $error("waitrequest stayed low past the answer cycle");
    // bus side: an idle bus never answers, and every read answer carries its data
    a_idle_no_answer: assert property (
        i_clk_en && !i_read && !i_write |=> o_waitrequest)
        else $error("waitrequest dropped without a request");
    a_read_answer: assert property (
        i_clk_en && i_resetn && i_read && o_waitrequest
        |=> !o_waitrequest && o_readdata == $past(rd_mux))
        else $error("read answer missing or wrong");
    a_dir_write: assert property (
        i_clk_en && i_resetn && wr_fire && sel_dir && i_byteenable[0]
        |=> dir_reg == $past(i_writedata[5:0]))
        else $error("direction write did not land");
    a_out_write: assert property (
        i_clk_en && i_resetn && wr_fire && sel_out && i_byteenable[0]
        |=> gpout_reg == $past(i_writedata[5:0]))
        else $error("output value write did not land");
    a_func_write: assert property (
        i_clk_en && i_resetn && wr_fire && sel_func && (&i_byteenable[1:0])
        |=> func_reg == $past(i_writedata[11:0]))
        else $error("pin function write did not land");
    a_ro_ignored: assert property (
        i_clk_en && i_resetn && wr_fire && (sel_status || sel_in)
        |=> $stable(func_reg) && $stable(dir_reg) && $stable(gpout_reg))
        else $error("write to a read-only register changed state");
endmodule : hss_top

// ---- tb/hss_board_model.sv ----
// Purpose: board side of the six strap pins: pull resistors and strap drivers
// Assumes: bit order of the strap vectors is the one the sampler uses
// Notes: a device drive wins over a board drive; contention is not modelled
`include "hss_map.svh"
module hss_board_model (
    // board drive control
    input wire logic [5:0] i_ext_en,
    input wire logic [5:0] i_ext_val,
    // device pad drive
    input wire logic [5:0] i_dev_out,
    input wire logic [5:0] i_dev_oe,
    // resolved wire
    output logic [5:0] o_level,
    output logic [5:0] o_driven
);
    timeunit 1ns;
    timeprecision 1ps;
    // an undriven pin settles to its termination, never to the last driven value
    wire logic [5:0] pull_level = `HSS_STRAP_DEFAULT;
    assign o_driven = i_ext_en;
    assign o_level = (i_dev_oe & i_dev_out) | (~i_dev_oe & i_ext_en & i_ext_val)
        | (~i_dev_oe & ~i_ext_en & pull_level);
endmodule : hss_board_model

// ---- tb/hardware_strap_sampler_test.sv ----
// Purpose: self-checking bench of the strap sampler over its register bus and pins
// Assumes: outputs are settled by the falling edge after the edge that launches them
// Notes: inputs move just after rising edges; direct output checks run at falling edges
`include "hss_map.svh"
module hardware_strap_sampler_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk;
    logic i_resetn;
    logic i_clk_en;
    logic i_core_power_good;
    logic [5:0] ext_en;
    logic [5:0] ext_val;
    logic [5:0] level;
    logic [5:0] driven;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [5:0] decoded;
    logic [5:0] exp_lvl;
    logic o_strap_valid;
    logic [16:0] i_fetch_addr;
    logic [16:0] o_fetch_addr;
    logic [7:0] i_address;
    logic i_read;
    logic i_write;
    logic [31:0] i_writedata;
    logic [3:0] i_byteenable;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic [31:0] rd;
    int fails;
    int tests_run;
    int cycles;
    // undriven, all low, all high, alternating, partly driven
    localparam logic [5:0] en_tab [5] = '{6'h00, 6'h3F, 6'h3F, 6'h3F, 6'h15};
    localparam logic [5:0] val_tab [5] = '{6'h00, 6'h00, 6'h3F, 6'h2A, 6'h3F};

    hss_board_model board (.i_ext_en(ext_en), .i_ext_val(ext_val), .i_dev_out(pin_out),
        .i_dev_oe(pin_oe), .o_level(level), .o_driven(driven));

    hss_top uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
        .i_core_power_good(i_core_power_good),
        .i_top_swap_strap_pin(level[0]), .i_top_swap_strap_pin_driven(driven[0]),
        .o_top_swap_strap_pin(pin_out[0]), .o_top_swap_strap_pin_oe(pin_oe[0]),
        .i_boot_source_strap_pin(level[1]), .i_boot_source_strap_pin_driven(driven[1]),
        .o_boot_source_strap_pin(pin_out[1]), .o_boot_source_strap_pin_oe(pin_oe[1]),
        .i_descriptor_security_strap_pin(level[2]),
        .i_descriptor_security_strap_pin_driven(driven[2]),
        .o_descriptor_security_strap_pin(pin_out[2]),
        .o_descriptor_security_strap_pin_oe(pin_oe[2]),
        .i_display_port0_detect_pin(level[3]), .i_display_port0_detect_pin_driven(driven[3]),
        .o_display_port0_detect_pin(pin_out[3]), .o_display_port0_detect_pin_oe(pin_oe[3]),
        .i_display_port1_detect_pin(level[4]), .i_display_port1_detect_pin_driven(driven[4]),
        .o_display_port1_detect_pin(pin_out[4]), .o_display_port1_detect_pin_oe(pin_oe[4]),
        .i_serial_panel_detect_pin(level[5]), .i_serial_panel_detect_pin_driven(driven[5]),
        .o_serial_panel_detect_pin(pin_out[5]), .o_serial_panel_detect_pin_oe(pin_oe[5]),
        .i_fetch_addr(i_fetch_addr), .o_fetch_addr(o_fetch_addr),
        .o_strap_valid(o_strap_valid), .o_top_swap_active(decoded[0]),
        .o_boot_from_spi(decoded[1]), .o_descriptor_override(decoded[2]),
        .o_display_port0_present(decoded[3]), .o_display_port1_present(decoded[4]),
        .o_serial_panel_present(decoded[5]),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest));

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    task automatic close_out;
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk

    // one access from the next rising edge; waitrequest is read where it is settled
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        input logic [3:0] be);
        @(posedge i_core_clk);
        i_address <= a;
        i_write <= wr;
        i_read <= ~wr;
        i_writedata <= wd;
        i_byteenable <= be;
        do @(negedge i_core_clk); while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        @(posedge i_core_clk);
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'h0);
        chk(rd, exp);
    endtask : rd_chk

    task automatic set_pg(input logic pg);
        @(posedge i_core_clk);
        i_core_power_good <= pg;
        repeat (3) @(negedge i_core_clk);
    endtask : set_pg

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        i_resetn = 1'b0;
        i_clk_en = 1'b1;
        i_core_power_good = 1'b0;
        ext_en = 6'h00;
        ext_val = 6'h00;
        i_fetch_addr = 17'h0ABCD;
        i_address = 8'h00;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0000_0000;
        i_byteenable = 4'h0;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        repeat (2) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        @(negedge i_core_clk);
        chk(32'({o_strap_valid, decoded}), 32'h0000_0003);
        rd_chk(`HSS_OFS_STATUS, 32'h0000_0007);
        rd_chk(`HSS_OFS_PIN_FUNC, 32'h0000_0000);
        rd_chk(`HSS_OFS_GPIO_DIR, 32'h0000_0000);
        rd_chk(8'h14, 32'h0000_0000);
        bus(1'b1, `HSS_OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
        rd_chk(`HSS_OFS_STATUS, 32'h0000_0007);
        bus(1'b1, `HSS_OFS_PIN_FUNC, 32'h0000_0FFF, 4'h1);
        rd_chk(`HSS_OFS_PIN_FUNC, 32'h0000_00FF);
        bus(1'b1, `HSS_OFS_PIN_FUNC, 32'h0000_0000, 4'hF);
        // pins set as outputs must stay off until the straps are captured
        bus(1'b1, `HSS_OFS_GPIO_DIR, 32'h0000_003F, 4'hF);
        bus(1'b1, `HSS_OFS_GPIO_OUT, 32'h0000_002A, 4'hF);
        @(negedge i_core_clk);
        chk(32'(pin_oe), 32'h0000_0000);
        set_pg(1'b1);
        chk(32'(pin_oe), 32'h0000_003F);
        chk(32'(pin_out), 32'h0000_002A);
        rd_chk(`HSS_OFS_STATUS, 32'h0000_0107);
        rd_chk(`HSS_OFS_GPIO_IN, 32'h0000_002A);
        // a pin moved off function 0 must stop driving even as an output
        bus(1'b1, `HSS_OFS_PIN_FUNC, 32'h0000_0001, 4'hF);
        repeat (2) @(negedge i_core_clk);
        chk(32'(pin_oe), 32'h0000_003E);
        rd_chk(`HSS_OFS_STATUS, 32'h0000_0107);
        bus(1'b1, `HSS_OFS_GPIO_DIR, 32'h0000_0000, 4'hF);
        for (int k = 0; k < 5; k++) begin
            ext_en <= en_tab[k];
            ext_val <= val_tab[k];
            set_pg(1'b0);
            chk(32'({o_strap_valid, decoded}), 32'h0000_0003);
            rd_chk(`HSS_OFS_STATUS, 32'h0000_0007);
            set_pg(1'b1);
            exp_lvl = (en_tab[k] & val_tab[k]) | (~en_tab[k] & `HSS_STRAP_DEFAULT);
            chk(32'(decoded), 32'(exp_lvl ^ 6'h04));
            chk(32'(o_fetch_addr), 32'(17'h0ABCD ^ {exp_lvl[0], 16'h0000}));
            rd_chk(`HSS_OFS_STATUS, 32'h0000_0100 | 32'(exp_lvl));
            // pins moving while power-good stays high must not reach the latch
            ext_en <= 6'h3F;
            ext_val <= ~exp_lvl;
            repeat (3) @(negedge i_core_clk);
            chk(32'(decoded), 32'(exp_lvl ^ 6'h04));
            rd_chk(`HSS_OFS_STATUS, 32'h0000_0100 | 32'(exp_lvl));
        end
        close_out();
    end
endmodule : hardware_strap_sampler_test
